// *** src/mmu_ctrl_pkg.sv ***
`default_nettype none

package mmu_ctrl_pkg;

    // Primary coprocessor register numbers.
    localparam logic [3:0] PRIM_BASE    = 4'h2;
    localparam logic [3:0] PRIM_DOMAIN  = 4'h3;
    localparam logic [3:0] PRIM_FAULT   = 4'h5;
    // Secondary opcode selectors.
    localparam logic [2:0] OP2_BASE_SEL = 3'h2;
    localparam logic [2:0] OP2_DATA     = 3'h0;
    localparam logic [2:0] OP2_INSTR    = 3'h1;
    localparam logic [2:0] OP2_DOMAIN   = 3'h0;
    localparam logic [3:0] SECOND_ZERO  = 4'h0;

    // Field positions.
    localparam int WIDTH_LSB    = 0;
    localparam int WIDTH_BITS   = 3;
    localparam int QUAL_BIT     = 12;
    localparam int DIR_BIT      = 11;
    localparam int TYPE_HI_BIT  = 10;
    localparam int DOMAIN_LSB   = 4;
    localparam int TYPE_LSB     = 0;

    // Values after reset.
    localparam logic [2:0]  BASE_SEL_RESET = 3'h0;
    localparam logic [31:0] DOMAIN_RESET   = 32'h0000_0000;
    localparam logic [31:0] FAULT_RESET    = 32'h0000_0000;

    // Storable bits of the two fault cause registers.
    localparam logic [31:0] DATA_FAULT_MASK  = 32'h0000_1cff;
    localparam logic [31:0] INSTR_FAULT_MASK = 32'h0000_14ff;

    // Table boundary size for base register 0 at width zero, in bytes.
    localparam logic [14:0] BOUNDARY_BASE = 15'h4000;

    // Domain permission encodings.
    localparam logic [1:0] DOM_NONE     = 2'h0;
    localparam logic [1:0] DOM_CLIENT   = 2'h1;
    localparam logic [1:0] DOM_RESERVED = 2'h2;
    localparam logic [1:0] DOM_MANAGER  = 2'h3;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       privileged;
        logic [3:0] primReg;
        logic [3:0] secondCoprocReg;
        logic [2:0] opcode2;
        logic [31:0] wdata;
    } coproc_req_type;

    typedef struct packed {
        logic       valid;
        logic       abortQualifier;
        logic       isWrite;
        logic       coprocOp;
        logic [3:0] domain;
        logic [4:0] faultType;
    } fault_event_type;

    typedef struct packed {
        logic       valid;
        logic [31:0] vaddr;
        logic [3:0] domain;
        logic       entryPermOk;
    } walk_req_type;

endpackage

`default_nettype wire

// *** src/translation_domain_fault_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module translation_domain_fault_regs (
    input  wire logic                            core_clk,
    input  wire logic                            rst,
    input  wire mmu_ctrl_pkg::coproc_req_type    coprocReq,
    output logic [31:0]                          coprocRdata,
    output logic                                 coprocUndef,
    input  wire mmu_ctrl_pkg::walk_req_type      walkReq,
    output logic                                 walkUseBase1,
    output logic                                 walkDomainFault,
    output logic                                 walkCheckPerm,
    output logic                                 walkPermFault,
    output logic [14:0]                          base0Boundary,
    input  wire mmu_ctrl_pkg::fault_event_type   dataAbort,
    input  wire mmu_ctrl_pkg::fault_event_type   prefetchAbort
);

    logic [2:0]  baseWidth_r;
    logic [2:0]  baseWidth_nxt;
    logic [31:0] domainFields_r;
    logic [31:0] domainFields_nxt;
    logic [31:0] dataFaultCause_r;
    logic [31:0] dataFaultCause_nxt;
    logic [31:0] instrFaultCause_r;
    logic [31:0] instrFaultCause_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic        undef_r;
    logic        undef_nxt;

    logic        selBase;
    logic        selDomain;
    logic        selData;
    logic        selInstr;
    logic        mapped;
    logic        allowed;
    logic [1:0]  walkField;
    logic [31:0] topMask;
    logic [31:0] dataCapture;
    logic [31:0] instrCapture;

    // Coprocessor register decode.
    always_comb begin
        selBase   = 1'b0;
        selDomain = 1'b0;
        selData   = 1'b0;
        selInstr  = 1'b0;
        if (coprocReq.secondCoprocReg != mmu_ctrl_pkg::SECOND_ZERO) begin
            selBase = 1'b0;
        end else if (coprocReq.primReg == mmu_ctrl_pkg::PRIM_BASE
                     && coprocReq.opcode2 == mmu_ctrl_pkg::OP2_BASE_SEL) begin
            selBase = 1'b1;
        end else if (coprocReq.primReg == mmu_ctrl_pkg::PRIM_DOMAIN
                     && coprocReq.opcode2 == mmu_ctrl_pkg::OP2_DOMAIN) begin
            selDomain = 1'b1;
        end else if (coprocReq.primReg == mmu_ctrl_pkg::PRIM_FAULT
                     && coprocReq.opcode2 == mmu_ctrl_pkg::OP2_DATA) begin
            selData = 1'b1;
        end else if (coprocReq.primReg == mmu_ctrl_pkg::PRIM_FAULT
                     && coprocReq.opcode2 == mmu_ctrl_pkg::OP2_INSTR) begin
            selInstr = 1'b1;
        end
    end

    assign mapped  = selBase | selDomain | selData | selInstr;
    assign allowed = coprocReq.valid & mapped & coprocReq.privileged;

    // Fault words assembled from the abort events.
    always_comb begin
        dataCapture = 32'h0000_0000;
        dataCapture[mmu_ctrl_pkg::QUAL_BIT] = dataAbort.abortQualifier;
        dataCapture[mmu_ctrl_pkg::DIR_BIT]  = dataAbort.isWrite | dataAbort.coprocOp;
        dataCapture[mmu_ctrl_pkg::TYPE_HI_BIT] = dataAbort.faultType[4];
        dataCapture[mmu_ctrl_pkg::DOMAIN_LSB +: 4] = dataAbort.domain;
        dataCapture[mmu_ctrl_pkg::TYPE_LSB +: 4] = dataAbort.faultType[3:0];
        instrCapture = 32'h0000_0000;
        instrCapture[mmu_ctrl_pkg::QUAL_BIT] = prefetchAbort.abortQualifier;
        instrCapture[mmu_ctrl_pkg::TYPE_HI_BIT] = prefetchAbort.faultType[4];
        instrCapture[mmu_ctrl_pkg::DOMAIN_LSB +: 4] = prefetchAbort.domain;
        instrCapture[mmu_ctrl_pkg::TYPE_LSB +: 4] = prefetchAbort.faultType[3:0];
    end

    // Register next values; a hardware abort wins over a software write.
    always_comb begin
        baseWidth_nxt       = baseWidth_r;
        domainFields_nxt    = domainFields_r;
        dataFaultCause_nxt  = dataFaultCause_r;
        instrFaultCause_nxt = instrFaultCause_r;
        if (allowed && coprocReq.write) begin
            if (selBase) begin
                baseWidth_nxt = coprocReq.wdata[mmu_ctrl_pkg::WIDTH_LSB +: mmu_ctrl_pkg::WIDTH_BITS];
            end else if (selDomain) begin
                domainFields_nxt = coprocReq.wdata;
            end else if (selData) begin
                dataFaultCause_nxt = coprocReq.wdata & mmu_ctrl_pkg::DATA_FAULT_MASK;
            end else if (selInstr) begin
                instrFaultCause_nxt = coprocReq.wdata & mmu_ctrl_pkg::INSTR_FAULT_MASK;
            end
        end
        if (dataAbort.valid) begin
            dataFaultCause_nxt = dataCapture;
        end
        if (prefetchAbort.valid) begin
            instrFaultCause_nxt = instrCapture;
        end
    end

    // Read data and undefined answer, one cycle after the request.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        undef_nxt = coprocReq.valid & ~allowed;
        if (allowed && !coprocReq.write) begin
            if (selBase) begin
                rdata_nxt = {29'h0, baseWidth_r};
            end else if (selDomain) begin
                rdata_nxt = domainFields_r;
            end else if (selData) begin
                rdata_nxt = dataFaultCause_r;
            end else if (selInstr) begin
                rdata_nxt = instrFaultCause_r;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            baseWidth_r       <= mmu_ctrl_pkg::BASE_SEL_RESET;
            domainFields_r    <= mmu_ctrl_pkg::DOMAIN_RESET;
            dataFaultCause_r  <= mmu_ctrl_pkg::FAULT_RESET;
            instrFaultCause_r <= mmu_ctrl_pkg::FAULT_RESET;
            rdata_r           <= 32'h0000_0000;
            undef_r           <= 1'b0;
        end else begin
            baseWidth_r       <= baseWidth_nxt;
            domainFields_r    <= domainFields_nxt;
            dataFaultCause_r  <= dataFaultCause_nxt;
            instrFaultCause_r <= instrFaultCause_nxt;
            rdata_r           <= rdata_nxt;
            undef_r           <= undef_nxt;
        end
    end

    assign coprocRdata = rdata_r;
    assign coprocUndef = undef_r;

    // Walk base selection and domain check, combinational on the walk request.
    always_comb begin
        topMask = 32'h0000_0000;
        for (int i = 0; i < 7; i++) begin
            if (i < int'(baseWidth_r)) begin
                topMask[31 - i] = 1'b1;
            end
        end
    end

    assign walkUseBase1 = walkReq.valid && (baseWidth_r != 3'h0)
                          && ((walkReq.vaddr & topMask) != 32'h0000_0000);
    assign base0Boundary = mmu_ctrl_pkg::BOUNDARY_BASE >> baseWidth_r;
    assign walkField = domainFields_r[{walkReq.domain, 1'b0} +: 2];

    always_comb begin
        walkDomainFault = 1'b0;
        walkCheckPerm   = 1'b0;
        case (walkField)
            mmu_ctrl_pkg::DOM_NONE:     walkDomainFault = walkReq.valid;
            mmu_ctrl_pkg::DOM_RESERVED: walkDomainFault = walkReq.valid;
            mmu_ctrl_pkg::DOM_CLIENT:   walkCheckPerm   = walkReq.valid;
            default:                    walkCheckPerm   = 1'b0;
        endcase
    end

    assign walkPermFault = walkCheckPerm & ~walkReq.entryPermOk;

    AST_WIDTH_ZERO_BASE0: assert property (@(posedge core_clk) disable iff (rst)
        (baseWidth_r == 3'h0) |-> !walkUseBase1)
        else $error("walk used base 1 with width zero");
    AST_TOP_BITS_SELECT: assert property (@(posedge core_clk) disable iff (rst)
        (walkReq.valid && baseWidth_r != 3'h0 && walkReq.vaddr[31]) |-> walkUseBase1)
        else $error("top address bit set but base 0 used");
    AST_BOUNDARY: assert property (@(posedge core_clk) disable iff (rst)
        (baseWidth_r == 3'h7) |-> (base0Boundary == 15'h0080))
        else $error("boundary wrong at width seven");
    AST_WIDTH_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        (allowed && coprocReq.write && selBase) |=> (baseWidth_r == $past(coprocReq.wdata[2:0])))
        else $error("width write not stored");
    AST_DOMAIN_FAULT: assert property (@(posedge core_clk) disable iff (rst)
        (walkReq.valid && !walkField[0]) |-> (walkDomainFault && !walkPermFault))
        else $error("domain fault missing");
    AST_MANAGER_NOPERM: assert property (@(posedge core_clk) disable iff (rst)
        (walkField == 2'h3) |-> (!walkPermFault && !walkDomainFault))
        else $error("manager domain faulted");
    AST_DATA_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
        (dataAbort.valid && dataAbort.coprocOp) |=> dataFaultCause_r[11])
        else $error("coprocessor abort not marked write");
    AST_DOMAIN_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
        dataAbort.valid |=> (dataFaultCause_r[7:4] == $past(dataAbort.domain)))
        else $error("fault domain not captured");
    AST_ZERO_BITS: assert property (@(posedge core_clk) disable iff (rst)
        (dataFaultCause_r[9:8] == 2'h0) && (instrFaultCause_r[11:8] & 4'hb) == 4'h0)
        else $error("reserved fault bits set");
    AST_USER_REJECT: assert property (@(posedge core_clk) disable iff (rst)
        (coprocReq.valid && !coprocReq.privileged) |=> (coprocUndef && $stable(domainFields_r)))
        else $error("user access not rejected");
    AST_RESET_STATE: assert property (@(posedge core_clk)
        rst |=> (baseWidth_r == mmu_ctrl_pkg::BASE_SEL_RESET
                 && domainFields_r == mmu_ctrl_pkg::DOMAIN_RESET
                 && coprocRdata == 32'h0000_0000 && !coprocUndef))
        else $error("state not cleared by reset");
    AST_BOUNDARY_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        (baseWidth_r == 3'h0) |-> (base0Boundary == 15'h4000))
        else $error("boundary wrong at width zero");
    AST_TOP_ZERO_BASE0: assert property (@(posedge core_clk) disable iff (rst)
        (walkReq.valid && baseWidth_r != 3'h0
         && (walkReq.vaddr >> (6'd32 - {3'h0, baseWidth_r})) == 32'h0) |-> !walkUseBase1)
        else $error("top address bits zero but base 1 used");
    AST_TOP_SET_BASE1: assert property (@(posedge core_clk) disable iff (rst)
        (walkReq.valid && baseWidth_r != 3'h0
         && (walkReq.vaddr >> (6'd32 - {3'h0, baseWidth_r})) != 32'h0) |-> walkUseBase1)
        else $error("top address bits set but base 0 used");
    AST_UPPER_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        (allowed && !coprocReq.write && selBase) |=> (coprocRdata[31:3] == 29'h0))
        else $error("base select upper bits not zero");
    AST_DOMAIN_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        (allowed && coprocReq.write && selDomain) |=> (domainFields_r == $past(coprocReq.wdata)))
        else $error("domain write not stored");
    AST_CLIENT_CHECK: assert property (@(posedge core_clk) disable iff (rst)
        (walkReq.valid && walkField == 2'h1) |->
            (walkCheckPerm && !walkDomainFault && (walkPermFault == !walkReq.entryPermOk)))
        else $error("client domain not checked");
    AST_WALK_IDLE: assert property (@(posedge core_clk) disable iff (rst)
        !walkReq.valid |-> (!walkUseBase1 && !walkDomainFault && !walkCheckPerm && !walkPermFault))
        else $error("walk answer without request");
    AST_DATA_DIR: assert property (@(posedge core_clk) disable iff (rst)
        dataAbort.valid |=> (dataFaultCause_r[11] == $past(dataAbort.isWrite | dataAbort.coprocOp)))
        else $error("data abort direction wrong");
    AST_DATA_QUAL: assert property (@(posedge core_clk) disable iff (rst)
        dataAbort.valid |=> (dataFaultCause_r[12] == $past(dataAbort.abortQualifier)))
        else $error("data abort qualifier wrong");
    AST_DATA_TYPE: assert property (@(posedge core_clk) disable iff (rst)
        dataAbort.valid |=> ({dataFaultCause_r[10], dataFaultCause_r[3:0]} == $past(dataAbort.faultType)))
        else $error("data abort type wrong");
    AST_DATA_SW_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        (allowed && coprocReq.write && selData && !dataAbort.valid) |=>
            (dataFaultCause_r == ($past(coprocReq.wdata) & 32'h0000_1cff)))
        else $error("data cause write not stored");
    AST_DATA_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        (!dataAbort.valid && !(allowed && coprocReq.write && selData)) |=> $stable(dataFaultCause_r))
        else $error("data cause changed without cause");
    AST_DATA_READ: assert property (@(posedge core_clk) disable iff (rst)
        (allowed && !coprocReq.write && selData) |=> (coprocRdata == $past(dataFaultCause_r)))
        else $error("data cause read wrong");
    AST_INSTR_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
        prefetchAbort.valid |=> (instrFaultCause_r == {19'h0, $past(prefetchAbort.abortQualifier),
            1'b0, $past(prefetchAbort.faultType[4]), 2'h0, $past(prefetchAbort.domain),
            $past(prefetchAbort.faultType[3:0])}))
        else $error("prefetch abort not captured");
    AST_INSTR_SW_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        (allowed && coprocReq.write && selInstr && !prefetchAbort.valid) |=>
            (instrFaultCause_r == ($past(coprocReq.wdata) & 32'h0000_14ff)))
        else $error("instr cause write not stored");
    AST_INSTR_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        (!prefetchAbort.valid && !(allowed && coprocReq.write && selInstr)) |=>
            $stable(instrFaultCause_r))
        else $error("instr cause changed without cause");
    AST_INSTR_READ: assert property (@(posedge core_clk) disable iff (rst)
        (allowed && !coprocReq.write && selInstr) |=> (coprocRdata == $past(instrFaultCause_r)))
        else $error("instr cause read wrong");
    AST_PRIV_ANSWER: assert property (@(posedge core_clk) disable iff (rst)
        (coprocReq.valid && allowed) |=> !coprocUndef)
        else $error("privileged access refused");
    AST_UNMAPPED: assert property (@(posedge core_clk) disable iff (rst)
        (coprocReq.valid && !mapped) |=> (coprocUndef && coprocRdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    AST_USER_KEEP: assert property (@(posedge core_clk) disable iff (rst)
        (coprocReq.valid && !coprocReq.privileged) |=>
            ($stable(baseWidth_r) && coprocRdata == 32'h0000_0000))
        else $error("user access changed state or read data");
    AST_NO_REQ_QUIET: assert property (@(posedge core_clk) disable iff (rst)
        !coprocReq.valid |=> (!coprocUndef && coprocRdata == 32'h0000_0000))
        else $error("answer without request");

    COV_BASE1: cover property (@(posedge core_clk) disable iff (rst) walkUseBase1);
    COV_DOMFAULT: cover property (@(posedge core_clk) disable iff (rst) walkDomainFault);
    COV_DATA_ABORT: cover property (@(posedge core_clk) disable iff (rst) dataAbort.valid);
    COV_UNDEF: cover property (@(posedge core_clk) disable iff (rst) coprocUndef);
    COV_PREFETCH_ABORT: cover property (@(posedge core_clk) disable iff (rst) prefetchAbort.valid);

endmodule // translation_domain_fault_regs

`default_nettype wire

// *** testbench/translation_domain_fault_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module translation_domain_fault_regs_tb_top;

    logic                            core_clk;
    logic                            rst;
    mmu_ctrl_pkg::coproc_req_type    coprocReq;
    logic [31:0]                     coprocRdata;
    logic                            coprocUndef;
    mmu_ctrl_pkg::walk_req_type      walkReq;
    logic                            walkUseBase1;
    logic                            walkDomainFault;
    logic                            walkCheckPerm;
    logic                            walkPermFault;
    logic [14:0]                     base0Boundary;
    mmu_ctrl_pkg::fault_event_type   dataAbort;
    mmu_ctrl_pkg::fault_event_type   prefetchAbort;
    logic [31:0]                     rdSeen;
    logic                            udSeen;
    int                              errCount;
    int                              numChecks;
    int                              cycles = 0;

    translation_domain_fault_regs i_translation_domain_fault_regs (
        .core_clk        (core_clk),
        .rst             (rst),
        .coprocReq       (coprocReq),
        .coprocRdata     (coprocRdata),
        .coprocUndef     (coprocUndef),
        .walkReq         (walkReq),
        .walkUseBase1    (walkUseBase1),
        .walkDomainFault (walkDomainFault),
        .walkCheckPerm   (walkCheckPerm),
        .walkPermFault   (walkPermFault),
        .base0Boundary   (base0Boundary),
        .dataAbort       (dataAbort),
        .prefetchAbort   (prefetchAbort)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One request, driven at the next edge and taken at the following one; answer sampled 1 ns after that edge.
    task automatic cop(input logic wr, input logic priv, input logic [3:0] prim,
                       input logic [3:0] sec, input logic [2:0] op2, input logic [31:0] wd);
        @(posedge core_clk);
        coprocReq <= '{1'b1, wr, priv, prim, sec, op2, wd};
        @(posedge core_clk);
        coprocReq.valid <= 1'b0;
        #1;
        rdSeen = coprocRdata;
        udSeen = coprocUndef;
    endtask

    task automatic rdchk(input string name, input logic [3:0] prim, input logic [2:0] op2,
                         input logic [31:0] exp);
        cop(1'b0, 1'b1, prim, 4'h0, op2, 32'h0);
        check(name, rdSeen, exp);
        check("undefOnRead", {31'h0, udSeen}, 32'h0);
    endtask

    task automatic walk(input logic [31:0] va, input logic [3:0] dom, input logic ok);
        @(posedge core_clk);
        walkReq <= '{1'b1, va, dom, ok};
        #1;
    endtask

    task automatic abt(input logic isData, input mmu_ctrl_pkg::fault_event_type ev);
        @(posedge core_clk);
        if (isData) begin
            dataAbort <= ev;
        end else begin
            prefetchAbort <= ev;
        end
        @(posedge core_clk);
        dataAbort.valid <= 1'b0;
        prefetchAbort.valid <= 1'b0;
    endtask

    task automatic test_done;
        $display("Checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errCount++;
            test_done();
        end
    end

    initial begin
        rst = 1'b1;
        coprocReq = '0;
        walkReq = '0;
        dataAbort = '0;
        prefetchAbort = '0;
        errCount = 0;
        numChecks = 0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rdchk("baseSelReset", mmu_ctrl_pkg::PRIM_BASE, mmu_ctrl_pkg::OP2_BASE_SEL, 32'h0);
        rdchk("dataReset", mmu_ctrl_pkg::PRIM_FAULT, mmu_ctrl_pkg::OP2_DATA, 32'h0);
        walk(32'hffff_ffff, 4'h0, 1'b1);
        check("resetBase1", {31'h0, walkUseBase1}, 32'h0);
        check("resetDomFault", {31'h0, walkDomainFault}, 32'h1);
        $display("Test reset done");
        for (int n = 0; n < 8; n++) begin
            cop(1'b1, 1'b1, mmu_ctrl_pkg::PRIM_BASE, 4'h0, mmu_ctrl_pkg::OP2_BASE_SEL, n);
            rdchk("baseSel", mmu_ctrl_pkg::PRIM_BASE, mmu_ctrl_pkg::OP2_BASE_SEL, n);
            check("boundary", {17'h0, base0Boundary}, {17'h0, 15'h4000 >> n});
            walk(32'hffff_ffff >> n, 4'h0, 1'b1);
            check("useBase0", {31'h0, walkUseBase1}, 32'h0);
            if (n > 0) begin
                walk(32'h1 << (32 - n), 4'h0, 1'b1);
                check("useBase1", {31'h0, walkUseBase1}, 32'h1);
            end
        end
        $display("Test base select done");
        cop(1'b1, 1'b1, mmu_ctrl_pkg::PRIM_DOMAIN, 4'h0, mmu_ctrl_pkg::OP2_DOMAIN, 32'he4e4_e4e4);
        rdchk("domains", mmu_ctrl_pkg::PRIM_DOMAIN, mmu_ctrl_pkg::OP2_DOMAIN, 32'he4e4_e4e4);
        for (int k = 0; k < 16; k++) begin
            walk(32'h0, 4'(k), 1'b0);
            check("domFault", {31'h0, walkDomainFault}, {31'h0, k % 2 == 0});
            check("checkPerm", {31'h0, walkCheckPerm}, {31'h0, k % 4 == 1});
            check("permFault", {31'h0, walkPermFault}, {31'h0, k % 4 == 1});
        end
        walk(32'h0, 4'h5, 1'b1);
        check("permOk", {31'h0, walkPermFault}, 32'h0);
        $display("Test domains done");
        cop(1'b1, 1'b0, mmu_ctrl_pkg::PRIM_DOMAIN, 4'h0, mmu_ctrl_pkg::OP2_DOMAIN, 32'h0);
        check("userUndef", {31'h0, udSeen}, 32'h1);
        rdchk("domKept", mmu_ctrl_pkg::PRIM_DOMAIN, mmu_ctrl_pkg::OP2_DOMAIN, 32'he4e4_e4e4);
        cop(1'b0, 1'b1, mmu_ctrl_pkg::PRIM_FAULT, 4'h1, mmu_ctrl_pkg::OP2_DATA, 32'h0);
        check("unmappedUndef", {31'h0, udSeen}, 32'h1);
        check("unmappedData", rdSeen, 32'h0);
        $display("Test refusal done");
        abt(1'b1, '{1'b1, 1'b1, 1'b0, 1'b1, 4'ha, 5'h15});
        rdchk("dataAbt", mmu_ctrl_pkg::PRIM_FAULT, mmu_ctrl_pkg::OP2_DATA, 32'h0000_1ca5);
        rdchk("instrKept", mmu_ctrl_pkg::PRIM_FAULT, mmu_ctrl_pkg::OP2_INSTR, 32'h0);
        abt(1'b1, '{1'b1, 1'b0, 1'b0, 1'b0, 4'h3, 5'h06});
        rdchk("dataOver", mmu_ctrl_pkg::PRIM_FAULT, mmu_ctrl_pkg::OP2_DATA, 32'h0000_0036);
        abt(1'b0, '{1'b1, 1'b1, 1'b1, 1'b1, 4'h5, 5'h1f});
        rdchk("instrAbt", mmu_ctrl_pkg::PRIM_FAULT, mmu_ctrl_pkg::OP2_INSTR, 32'h0000_145f);
        rdchk("dataKept", mmu_ctrl_pkg::PRIM_FAULT, mmu_ctrl_pkg::OP2_DATA, 32'h0000_0036);
        abt(1'b1, '{1'b1, 1'b0, 1'b1, 1'b0, 4'h7, 5'h02});
        rdchk("dataWrite", mmu_ctrl_pkg::PRIM_FAULT, mmu_ctrl_pkg::OP2_DATA, 32'h0000_0872);
        $display("Test aborts done");
        cop(1'b1, 1'b1, mmu_ctrl_pkg::PRIM_FAULT, 4'h0, mmu_ctrl_pkg::OP2_DATA, 32'hffff_ffff);
        rdchk("dataWr", mmu_ctrl_pkg::PRIM_FAULT, mmu_ctrl_pkg::OP2_DATA, 32'h0000_1cff);
        cop(1'b1, 1'b1, mmu_ctrl_pkg::PRIM_FAULT, 4'h0, mmu_ctrl_pkg::OP2_INSTR, 32'h0000_000c);
        rdchk("instrWr", mmu_ctrl_pkg::PRIM_FAULT, mmu_ctrl_pkg::OP2_INSTR, 32'h0000_000c);
        $display("Test software writes done");
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rdchk("baseSelAgain", mmu_ctrl_pkg::PRIM_BASE, mmu_ctrl_pkg::OP2_BASE_SEL, 32'h0);
        rdchk("instrAgain", mmu_ctrl_pkg::PRIM_FAULT, mmu_ctrl_pkg::OP2_INSTR, 32'h0);
        $display("Test second reset done");
        test_done();
    end

endmodule // translation_domain_fault_regs_tb_top

`default_nettype wire
